// *** logic/ncd_consts.svh ***
// Constants for the Clear and Write NVM command decoder
`ifndef NCD_CONSTS_SVH
`define NCD_CONSTS_SVH

// Command codes and addresses
`define NCD_CMD_CLEAR       4'h7
`define NCD_CMD_UNIMPL      4'h8
`define NCD_CMD_WRITE_NVM   4'h9
`define NCD_GLOBAL_ADDR     4'h0

// Mirror location that holds the bus address
`define NCD_ADDR_LOC_BANK   2'h1
`define NCD_ADDR_LOC_NIBBLE 4'h7

// Response constant fields
`define NCD_RESP_ARMED_ONES 2'h3
`define NCD_RESP_PLAIN_MID  8'h0f

// Register byte offsets
`define NCD_OFS_CTRL        8'h00
`define NCD_OFS_ADDR        8'h04
`define NCD_OFS_STATUS      8'h08
`define NCD_OFS_RESP        8'h0c

// Control register fields
`define NCD_CTRL_ARM        0
`define NCD_CTRL_BANK_LO    1
`define NCD_CTRL_BANK_HI    2
`define NCD_CTRL_ENH_LONG   3
`define NCD_CTRL_ENH_SHORT  4

// Status register fields
`define NCD_STAT_SW_OPEN    0
`define NCD_STAT_BUSY       1
`define NCD_STAT_LRESET     2

// Reset values
`define NCD_CTRL_RST        5'h00
`define NCD_ADDR_RST        4'h0
`define NCD_SW_OPEN_RST     1'b1

// AXI responses
`define NCD_RESP_OKAY       2'h0
`define NCD_RESP_SLVERR     2'h2

// Timing
`define NCD_CLK_PERIOD_NS   10
`define NCD_PER_BIT_PROGRAM_TIME_NS 1000
`define NCD_PROG_BIT_CYC    ((`NCD_PER_BIT_PROGRAM_TIME_NS + `NCD_CLK_PERIOD_NS - 1) / `NCD_CLK_PERIOD_NS)

`endif

// *** logic/ncd_pkg.sv ***
// Types for the Clear and Write NVM command decoder
package ncd_pkg;

   typedef enum logic [1:0] {
      FMT_STD_LONG  = 2'h0,
      FMT_STD_SHORT = 2'h1,
      FMT_ENH_LONG  = 2'h2,
      FMT_ENH_SHORT = 2'h3
   } ncd_fmt_t;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_WRITE = 5'h02,
      ST_READ  = 5'h04,
      ST_RESP  = 5'h08,
      ST_PROG  = 5'h10
   } ncd_state_t;

endpackage

// *** logic/ncd_mem_if.sv ***
// Port bundle between the decoder and its nibble memory
`timescale 1ns/10ps
interface ncd_mem_if #(
   parameter int AW = 6,
   parameter int DW = 4
);
   logic          wr_en;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata;
   logic [DW-1:0] rdata;

   modport ctrl (output wr_en, output addr, output wdata, input rdata);
   modport mem  (input wr_en, input addr, input wdata, output rdata);
endinterface

// *** logic/ncd_nibble_mem.sv ***
// Mirror and programmable nibble store with registered read
`timescale 1ns/10ps
module ncd_nibble_mem #(
   parameter int AW = 6,
   parameter int DW = 4
) (
   input  wire logic core_clk,
   input  wire logic sys_rst,
   ncd_mem_if.mem    port
);
   logic [DW-1:0] cell_q [2**AW];

   // Cell storage
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < 2**AW; i++) begin
            cell_q[i] <= '0;
         end
      end else if (port.wr_en) begin
         cell_q[port.addr] <= port.wdata;
      end
   end

   // Registered read data
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         port.rdata <= '0;
      end else begin
         port.rdata <= cell_q[port.addr];
      end
   end
endmodule

// *** logic/ncd_top.sv ***
// Clear and Write NVM command decoder with AXI4-Lite registers
//
// Behaviour
// (RQ1) Clear accepted in all four formats
// (RQ2) Clear command code is 0111
// (RQ3) Clear needs own or global address
// (RQ4) Clear opens switch, resets device logic
// (RQ5) Clear data bits are ignored
// (RQ6) Clear sends no response
// (RQ7) Clear with foreign address is discarded
// (RQ8) Command code 1000 is always ignored
// (RQ9) Write NVM only in long formats
// (RQ10) Write NVM ignored while address is zero
// (RQ11) Write NVM command code is 1001
// (RQ12) Data: nibble select high, value low
// (RQ13) Armed write programs selected nibble
// (RQ14) Write NVM needs exact own address
// (RQ15) Armed response: addr, nibble, ones, bank, data
// (RQ16) Response bank bits show chosen bank
// (RQ17) Unarmed: update mirror, echo address
// (RQ18) Changed address appears in response
// (RQ19) Master waits out the programming time
// (RQ20) Ignored command changes nothing at all
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
`include "ncd_consts.svh"
module ncd_top
   import ncd_pkg::*;
#(
   parameter int AXI_AW       = 8,
   parameter int PROG_BIT_CYC = `NCD_PROG_BIT_CYC
) (
   input  wire logic              core_clk,
   input  wire logic              sys_rst,
   input  wire logic              frame_valid,
   input  wire logic [3:0]        frame_cmd,
   input  wire logic [3:0]        frame_addr,
   input  wire logic [7:0]        frame_data,
   input  wire logic [1:0]        frame_fmt,
   input  wire logic              frame_crc_ok,
   output logic                   bus_switch_open_q,
   output logic                   logic_reset_q,
   output logic                   resp_valid_q,
   output logic [15:0]            resp_data_q,
   output logic                   prog_busy_q,
   input  wire logic [AXI_AW-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [AXI_AW-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);
   ncd_mem_if #(.AW(6), .DW(4)) mem_bus ();

   ncd_state_t         state_q;
   logic [4:0]         ctrl_q;
   logic [3:0]         assigned_bus_address_q;
   logic [3:0]         nibble_select_q;
   logic [3:0]         value_q;
   logic [1:0]         bank_q;
   logic               armed_q;
   logic [15:0]        prog_cnt_q;
   logic [15:0]        prog_cyc;
   logic [2:0]         bit_cnt;
   logic               otp_write_arm;
   logic [1:0]         bank_sel;
   logic               fmt_ok_clear;
   logic               fmt_ok_long;
   logic               accept_clear;
   logic               accept_write;
   logic               addr_loc_hit;
   logic [AXI_AW-1:0]  aw_addr_q;
   logic [31:0]        w_data_q;
   logic [3:0]         w_strb_q;
   logic               aw_full_q;
   logic               w_full_q;
   logic               do_write;
   logic               wr_ctrl;
   logic               wr_addr;
   logic               wr_status;
   logic               wr_mapped;
   logic [31:0]        rd_mux;
   logic               rd_mapped;

   assign otp_write_arm = ctrl_q[`NCD_CTRL_ARM];
   assign bank_sel      = ctrl_q[`NCD_CTRL_BANK_HI:`NCD_CTRL_BANK_LO];

   // (RQ1) Clear format check
   always_comb begin
      case (ncd_fmt_t'(frame_fmt))
         FMT_STD_LONG:  fmt_ok_clear = 1'b1;
         FMT_STD_SHORT: fmt_ok_clear = 1'b1;
         FMT_ENH_LONG:  fmt_ok_clear = ctrl_q[`NCD_CTRL_ENH_LONG];
         FMT_ENH_SHORT: fmt_ok_clear = ctrl_q[`NCD_CTRL_ENH_SHORT];
         default:       fmt_ok_clear = 1'b0;
      endcase
   end

   // (RQ9) Long formats only
   always_comb begin
      case (ncd_fmt_t'(frame_fmt))
         FMT_STD_LONG: fmt_ok_long = 1'b1;
         FMT_ENH_LONG: fmt_ok_long = ctrl_q[`NCD_CTRL_ENH_LONG];
         default:      fmt_ok_long = 1'b0;
      endcase
   end

   // (RQ2) (RQ3) (RQ5) (RQ7) Clear decode, data unused
   assign accept_clear = frame_valid && frame_crc_ok && fmt_ok_clear
                         && (frame_cmd == `NCD_CMD_CLEAR)
                         && ((frame_addr == assigned_bus_address_q)
                             || (frame_addr == `NCD_GLOBAL_ADDR));

   // (RQ10) (RQ11) (RQ14) Write NVM decode; (RQ8) other codes fall through
   assign accept_write = frame_valid && frame_crc_ok && fmt_ok_long
                         && (state_q == ST_IDLE)
                         && (frame_cmd == `NCD_CMD_WRITE_NVM)
                         && (assigned_bus_address_q != `NCD_GLOBAL_ADDR)
                         && (frame_addr == assigned_bus_address_q);

   assign addr_loc_hit = (bank_q == `NCD_ADDR_LOC_BANK) && (nibble_select_q == `NCD_ADDR_LOC_NIBBLE);

   // Bits being programmed, at least one
   always_comb begin
      bit_cnt = 3'(value_q[0]) + 3'(value_q[1]) + 3'(value_q[2]) + 3'(value_q[3]);
      if (bit_cnt == 3'h0) begin
         bit_cnt = 3'h1;
      end
      prog_cyc = 16'(PROG_BIT_CYC) * 16'(bit_cnt);
   end

   // Memory access from latched command
   assign mem_bus.wr_en = (state_q == ST_WRITE);
   assign mem_bus.addr  = {bank_q, nibble_select_q};
   assign mem_bus.wdata = value_q;

   ncd_nibble_mem #(.AW(6), .DW(4)) u_mem (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .port     (mem_bus.mem)
   );

   // (RQ12) (RQ16) Latch command fields and bank
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         nibble_select_q <= 4'h0;
         value_q         <= 4'h0;
         bank_q          <= 2'h0;
         armed_q         <= 1'b0;
      end else if (accept_write && !accept_clear) begin
         nibble_select_q <= frame_data[7:4];
         value_q         <= frame_data[3:0];
         bank_q          <= bank_sel;
         armed_q         <= otp_write_arm;
      end
   end

   // Command sequencer
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q    <= ST_IDLE;
         prog_cnt_q <= 16'h0;
      end else if (accept_clear) begin
         // (RQ4) Clear resets sequencer
         state_q    <= ST_IDLE;
         prog_cnt_q <= 16'h0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               // (RQ20) Ignored frames leave state alone
               if (accept_write) begin
                  state_q <= ST_WRITE;
               end
            end
            ST_WRITE: begin
               state_q <= ST_READ;
            end
            ST_READ: begin
               state_q <= ST_RESP;
            end
            ST_RESP: begin
               // (RQ19) Programming time per bit
               if (armed_q) begin
                  state_q    <= ST_PROG;
                  prog_cnt_q <= prog_cyc;
               end else begin
                  state_q <= ST_IDLE;
               end
            end
            ST_PROG: begin
               if (prog_cnt_q <= 16'h1) begin
                  state_q    <= ST_IDLE;
                  prog_cnt_q <= 16'h0;
               end else begin
                  prog_cnt_q <= prog_cnt_q - 16'h1;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Response frame
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         resp_valid_q <= 1'b0;
         resp_data_q  <= 16'h0;
      end else if (accept_clear) begin
         // (RQ6) No response on Clear
         resp_valid_q <= 1'b0;
      end else if (state_q == ST_RESP) begin
         resp_valid_q <= 1'b1;
         if (armed_q) begin
            // (RQ13) (RQ15) (RQ16) Armed layout
            resp_data_q <= {assigned_bus_address_q, nibble_select_q, `NCD_RESP_ARMED_ONES, bank_q, mem_bus.rdata};
         end else begin
            // (RQ17) (RQ18) Address echo, new value
            resp_data_q <= {assigned_bus_address_q, `NCD_RESP_PLAIN_MID, assigned_bus_address_q};
         end
      end else begin
         resp_valid_q <= 1'b0;
      end
   end

   // Busy flag
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         prog_busy_q <= 1'b0;
      end else begin
         prog_busy_q <= !accept_clear && ((state_q == ST_PROG && prog_cnt_q > 16'h1)
                        || (state_q == ST_RESP && armed_q));
      end
   end

   // (RQ4) Switch open and logic reset pulse
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bus_switch_open_q <= `NCD_SW_OPEN_RST;
         logic_reset_q     <= 1'b0;
      end else begin
         logic_reset_q <= accept_clear;
         if (accept_clear) begin
            bus_switch_open_q <= 1'b1;
         end else if (wr_status && w_strb_q[0] && w_data_q[`NCD_STAT_SW_OPEN]) begin
            bus_switch_open_q <= 1'b0;
         end
      end
   end

   // AXI write channel capture
   assign do_write  = aw_full_q && w_full_q && !s_axi_bvalid;
   assign wr_ctrl   = do_write && (aw_addr_q[AXI_AW-1:2] == `NCD_OFS_CTRL >> 2);
   assign wr_addr   = do_write && (aw_addr_q[AXI_AW-1:2] == `NCD_OFS_ADDR >> 2);
   assign wr_status = do_write && (aw_addr_q[AXI_AW-1:2] == `NCD_OFS_STATUS >> 2);
   assign wr_mapped = wr_ctrl || wr_addr || wr_status
                      || (aw_addr_q[AXI_AW-1:2] == `NCD_OFS_RESP >> 2);

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_awready <= 1'b1;
         aw_full_q     <= 1'b0;
         aw_addr_q     <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         aw_full_q     <= 1'b1;
         aw_addr_q     <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
         aw_full_q     <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_wready <= 1'b1;
         w_full_q     <= 1'b0;
         w_data_q     <= 32'h0;
         w_strb_q     <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         w_full_q     <= 1'b1;
         w_data_q     <= s_axi_wdata;
         w_strb_q     <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
         w_full_q     <= 1'b0;
      end
   end

   // Write response
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `NCD_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_mapped ? `NCD_RESP_OKAY : `NCD_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Control register; Clear returns it to reset
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_q <= `NCD_CTRL_RST;
      end else if (accept_clear) begin
         ctrl_q <= `NCD_CTRL_RST;
      end else if (wr_ctrl && w_strb_q[0]) begin
         ctrl_q <= w_data_q[4:0];
      end
   end

   // Bus address; (RQ18) Write NVM to address location wins
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         assigned_bus_address_q <= `NCD_ADDR_RST;
      end else if (state_q == ST_WRITE && addr_loc_hit) begin
         assigned_bus_address_q <= value_q;
      end else if (wr_addr && w_strb_q[0]) begin
         assigned_bus_address_q <= w_data_q[3:0];
      end
   end

   // Read data mux
   always_comb begin
      rd_mux    = 32'h0;
      rd_mapped = 1'b1;
      case (s_axi_araddr[AXI_AW-1:2])
         `NCD_OFS_CTRL >> 2: begin
            rd_mux[4:0] = ctrl_q;
         end
         `NCD_OFS_ADDR >> 2: begin
            rd_mux[3:0] = assigned_bus_address_q;
         end
         `NCD_OFS_STATUS >> 2: begin
            rd_mux[`NCD_STAT_SW_OPEN] = bus_switch_open_q;
            rd_mux[`NCD_STAT_BUSY]    = (state_q != ST_IDLE);
            rd_mux[`NCD_STAT_LRESET]  = logic_reset_q;
         end
         `NCD_OFS_RESP >> 2: begin
            rd_mux[15:0] = resp_data_q;
         end
         default: begin
            rd_mapped = 1'b0;
         end
      endcase
   end

   // Read channel
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= `NCD_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_mux;
         s_axi_rresp   <= rd_mapped ? `NCD_RESP_OKAY : `NCD_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
      end
   end
endmodule

// *** tb/ncd_top_chk.sv ***
// Port assertions for the command decoder
`timescale 1ns/10ps
module ncd_top_chk #(
   parameter int PROG_BIT_CYC = 2
) (
   input wire logic        core_clk,
   input wire logic        sys_rst,
   input wire logic        frame_valid,
   input wire logic [3:0]  frame_cmd,
   input wire logic [3:0]  frame_addr,
   input wire logic [7:0]  frame_data,
   input wire logic [1:0]  frame_fmt,
   input wire logic        frame_crc_ok,
   input wire logic        bus_switch_open_q,
   input wire logic        logic_reset_q,
   input wire logic        resp_valid_q,
   input wire logic [15:0] resp_data_q,
   input wire logic        prog_busy_q
);
   logic [7:0] busy_cnt_q;
   logic       nvm_ok;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   assign nvm_ok = frame_valid && frame_crc_ok && frame_cmd == 4'h9 && !frame_fmt[0] && frame_addr != 4'h0;
   // Length of a busy run
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) busy_cnt_q <= 8'h00;
      else if (prog_busy_q) busy_cnt_q <= busy_cnt_q + 8'h01;
      else busy_cnt_q <= 8'h00;
   end
   sequence glb_clear;
      frame_valid && frame_crc_ok && frame_cmd == 4'h7 && frame_addr == 4'h0 && !frame_fmt[1];
   endsequence
   sequence no_resp;
      !resp_valid_q [*4];
   endsequence
   clr_open_a: assert property (glb_clear |=> bus_switch_open_q && logic_reset_q)
      else $error("global clear did not open switch");
   clr_quiet_a: assert property (glb_clear |-> ##2 no_resp)
      else $error("response after clear");
   rst_cause_a: assert property ($rose(logic_reset_q) |-> $past(frame_valid && frame_crc_ok && frame_cmd == 4'h7))
      else $error("logic reset without clear frame");
   rst_switch_a: assert property (logic_reset_q |-> bus_switch_open_q)
      else $error("logic reset with switch closed");
   resp_cause_a: assert property (resp_valid_q |-> $past(nvm_ok, 4))
      else $error("response without write frame");
   resp_ones_a: assert property (resp_valid_q |-> resp_data_q[7:6] == 2'h3)
      else $error("response bits 7:6 wrong");
   armed_nib_a: assert property (resp_valid_q && prog_busy_q |-> resp_data_q[11:8] == $past(frame_data[7:4], 4))
      else $error("armed response nibble select wrong");
   plain_echo_a: assert property (resp_valid_q && !prog_busy_q |->
      resp_data_q[11:4] == 8'h0f && resp_data_q[15:12] == resp_data_q[3:0])
      else $error("unarmed response form wrong");
   busy_start_a: assert property ($rose(prog_busy_q) |-> resp_valid_q)
      else $error("busy without response");
   busy_len_a: assert property (busy_cnt_q <= 8'(4 * PROG_BIT_CYC))
      else $error("programming wait too long");
endmodule

// *** tb/ncd_frame_src.sv ***
// Bus master model sending decoded frames
`timescale 1ns/10ps
module ncd_frame_src #(
   parameter int GAP = 16
) (
   input  wire logic core_clk,
   output logic       frame_valid,
   output logic [3:0] frame_cmd,
   output logic [3:0] frame_addr,
   output logic [7:0] frame_data,
   output logic [1:0] frame_fmt,
   output logic       frame_crc_ok
);
   initial begin
      frame_valid = 1'b0;
      frame_cmd = 4'h0;
      frame_addr = 4'h0;
      frame_data = 8'h00;
      frame_fmt = 2'h0;
      frame_crc_ok = 1'b0;
   end
   task automatic send(input logic [3:0] c, input logic [3:0] a, input logic [7:0] d,
                       input logic [1:0] f, input logic k);
      @(posedge core_clk);
      frame_valid <= 1'b1;
      frame_cmd <= c;
      frame_addr <= a;
      frame_data <= d;
      frame_fmt <= f;
      frame_crc_ok <= k;
      @(posedge core_clk);
      frame_valid <= 1'b0;
      frame_cmd <= ~c;
      frame_addr <= ~a;
      frame_data <= ~d;
      frame_fmt <= ~f;
      frame_crc_ok <= 1'b0;
      repeat (GAP) @(posedge core_clk);
   endtask
endmodule

// *** tb/tb_top.sv ***
// Testbench for the command decoder
`timescale 1ns/10ps
module tb_top;
   logic        core_clk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, frame_data;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb, frame_cmd, frame_addr;
   logic [1:0]  s_axi_bresp, s_axi_rresp, frame_fmt;
   logic        frame_valid, frame_crc_ok, bus_switch_open_q, logic_reset_q;
   logic        resp_valid_q, prog_busy_q;
   logic [15:0] resp_data_q, last_resp;
   int          error_cnt, cmp_count, cyc, rst_cnt, resp_cnt, busy_cnt;

   ncd_frame_src #(.GAP(16)) src (.core_clk(core_clk), .frame_valid(frame_valid), .frame_cmd(frame_cmd),
      .frame_addr(frame_addr), .frame_data(frame_data), .frame_fmt(frame_fmt), .frame_crc_ok(frame_crc_ok));
   ncd_top #(.AXI_AW(8), .PROG_BIT_CYC(2)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
      .frame_valid(frame_valid), .frame_cmd(frame_cmd), .frame_addr(frame_addr), .frame_data(frame_data),
      .frame_fmt(frame_fmt), .frame_crc_ok(frame_crc_ok), .bus_switch_open_q(bus_switch_open_q),
      .logic_reset_q(logic_reset_q), .resp_valid_q(resp_valid_q), .resp_data_q(resp_data_q),
      .prog_busy_q(prog_busy_q), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

   always #5 core_clk = ~core_clk;

   task automatic end_of_test();
      $display("cmp_count=%0d error_cnt=%0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      chk({30'h0, s_axi_bresp}, {30'h0, er});
   endtask

   task automatic axr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, exp);
      chk({30'h0, s_axi_rresp}, {30'h0, er});
   endtask

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (logic_reset_q === 1'b1) rst_cnt <= rst_cnt + 1;
      if (prog_busy_q === 1'b1) busy_cnt <= busy_cnt + 1;
      if (resp_valid_q === 1'b1) begin
         resp_cnt <= resp_cnt + 1;
         last_resp <= resp_data_q;
      end
      if (cyc == 2000) begin
         error_cnt++;
         end_of_test();
      end
   end

   initial begin
      core_clk = 1'b0;
      sys_rst = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      {error_cnt, cmp_count, cyc, rst_cnt, resp_cnt, busy_cnt} = '0;
      last_resp = 16'h0;
      repeat (20) @(posedge core_clk);
      sys_rst <= 1'b0;
      axr(8'h00, 32'h0, 2'h0);
      axr(8'h04, 32'h0, 2'h0);
      axr(8'h08, 32'h1, 2'h0);
      axr(8'h10, 32'h0, 2'h2);
      axw(8'h10, 32'h1, 2'h2);
      src.send(4'h9, 4'h0, 8'h71, 2'h0, 1'b1);
      chk(32'(resp_cnt), 32'h0);
      axw(8'h04, 32'h5, 2'h0);
      axw(8'h08, 32'h1, 2'h0);
      chk({31'h0, bus_switch_open_q}, 32'h0);
      src.send(4'h7, 4'h3, 8'h00, 2'h0, 1'b1);
      src.send(4'h7, 4'h5, 8'h00, 2'h0, 1'b0);
      for (int f = 0; f < 4; f++) src.send(4'h8, 4'h5, 8'hff, 2'(f), 1'b1);
      src.send(4'h9, 4'h5, 8'h3a, 2'h1, 1'b1);
      src.send(4'h9, 4'h5, 8'h3a, 2'h2, 1'b1);
      src.send(4'h9, 4'h6, 8'h3a, 2'h0, 1'b1);
      src.send(4'h9, 4'h0, 8'h3a, 2'h0, 1'b1);
      chk(32'(rst_cnt), 32'h0);
      chk(32'(resp_cnt), 32'h0);
      chk({31'h0, bus_switch_open_q}, 32'h0);
      axr(8'h04, 32'h5, 2'h0);
      src.send(4'h9, 4'h5, 8'h3a, 2'h0, 1'b1);
      chk(32'(resp_cnt), 32'h1);
      chk({16'h0, last_resp}, 32'h50f5);
      axw(8'h00, 32'h5, 2'h0);
      src.send(4'h9, 4'h5, 8'hc6, 2'h0, 1'b1);
      chk({16'h0, last_resp}, 32'h5ce6);
      chk(32'(busy_cnt), 32'h4);
      axw(8'h0c, 32'hffff, 2'h0);
      axr(8'h0c, 32'h5ce6, 2'h0);
      axw(8'h00, 32'ha, 2'h0);
      src.send(4'h9, 4'h5, 8'h79, 2'h2, 1'b1);
      chk({16'h0, last_resp}, 32'h90f9);
      axr(8'h04, 32'h9, 2'h0);
      for (int f = 0; f < 4; f++) begin
         axw(8'h00, 32'h18, 2'h0);
         axw(8'h08, 32'h1, 2'h0);
         src.send(4'h7, f[0] ? 4'h9 : 4'h0, 8'(f * 85), 2'(f), 1'b1);
         chk({31'h0, bus_switch_open_q}, 32'h1);
         chk(32'(rst_cnt), 32'(f + 1));
      end
      axr(8'h00, 32'h0, 2'h0);
      chk(32'(resp_cnt), 32'h3);
      axw(8'h08, 32'h1, 2'h0);
      src.send(4'h7, 4'h0, 8'h00, 2'h3, 1'b1);
      chk({31'h0, bus_switch_open_q}, 32'h0);
      end_of_test();
   end
endmodule

bind ncd_top ncd_top_chk #(.PROG_BIT_CYC(PROG_BIT_CYC)) u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
   .frame_valid(frame_valid), .frame_cmd(frame_cmd), .frame_addr(frame_addr), .frame_data(frame_data),
   .frame_fmt(frame_fmt), .frame_crc_ok(frame_crc_ok), .bus_switch_open_q(bus_switch_open_q),
   .logic_reset_q(logic_reset_q), .resp_valid_q(resp_valid_q), .resp_data_q(resp_data_q),
   .prog_busy_q(prog_busy_q));
